// ---- core/msc_machine_state_control.sv ----
`timescale 1ns/1ns
`include "msc_cfg.svh"
module msc_machine_state_control (
	input  wire logic              clk_sys,
	input  wire logic              resetn,
	input  wire logic              vector_top_strap,
	input  wire msc_pkg::msc_req_t req,
	input  wire msc_pkg::msc_exc_t exc,
	input  wire logic              instr_done,
	input  wire logic              instr_fault,
	input  wire logic              branch_done,
	input  wire logic              ext_int_req,
	input  wire logic              dec_req,
	input  wire logic              hw_fault_req,
	input  wire logic              float_exc_req,
	output logic [31:0]            machine_state,
	output logic [31:0]            saved_state,
	output logic [31:0]            access_fault_cause,
	output logic [31:0]            fault_address,
	output msc_pkg::msc_ctl_t      ctl,
	output logic                   trace_exc,
	output logic                   async_take,
	output logic                   hw_fault_take,
	output logic                   float_assist_take
);
	import msc_pkg::*;

	// Architectural registers
	logic [31:0] ms_reg;
	logic [31:0] ms_next;
	logic [31:0] save_reg;
	logic [31:0] cause_reg;
	logic [31:0] addr_reg;
	logic        strap_seen_reg;

	// Decoded control flops, one per field
	logic        run_little_reg;
	logic        async_ok_reg;
	logic        super_ok_reg;
	logic        float_ok_reg;
	logic        hw_fault_ok_reg;
	logic        step_trace_reg;
	logic        in_order_reg;
	logic        jump_trace_reg;
	logic        precise_reg;
	logic        restart_ok_reg;
	logic [31:0] vector_base_reg;

	// Gated event flops
	logic        trace_reg;
	logic        async_reg;
	logic        hw_fault_reg;
	logic        float_reg;

	// Byte order, interrupt gate, privilege, unit enable and restart taps
	wire        ms_trap_order  = ms_reg[`MSC_B_TRAP_ORDER];
	wire        ms_run_order   = ms_reg[`MSC_B_RUN_ORDER];
	wire        ms_async_gate  = ms_reg[`MSC_B_ASYNC_GATE];
	wire        ms_nonsuper    = ms_reg[`MSC_B_NONSUPER];
	wire        ms_float_on    = ms_reg[`MSC_B_FLOAT_ON];
	wire        ms_hw_fault_on = ms_reg[`MSC_B_HW_FAULT_ON];
	wire        ms_restart_ok  = ms_reg[`MSC_B_RESTART_OK];

	// Trace, vector and float mode taps
	wire        ms_step_trace  = ms_reg[`MSC_B_STEP_TRACE];
	wire        ms_jump_trace  = ms_reg[`MSC_B_JUMP_TRACE];
	wire        ms_vector_top  = ms_reg[`MSC_B_VECTOR_TOP];
	wire [1:0]  fmode          = {ms_reg[`MSC_B_FMODE_HI], ms_reg[`MSC_B_FMODE_LO]};

	// Exception entry state: run order follows the old trap order
	wire [31:0] entry_base     = exc.new_ms & `MSC_MS_MASK & ~(32'h1 << `MSC_B_RUN_ORDER);
	wire [31:0] entry_order    = {31'h0, ms_trap_order} << `MSC_B_RUN_ORDER;
	wire [31:0] exc_ms         = entry_base | entry_order;

	// Software writes: move, system call and return all land
	wire        src_move       = (req.ms_src == MSC_WR_MOVE);
	wire        src_syscall    = (req.ms_src == MSC_WR_SYSCALL);
	wire        src_return     = (req.ms_src == MSC_WR_RETURN);
	wire        wr_ms_hit      = req.ms_write && (src_move || src_syscall || src_return);
	wire [31:0] wr_ms          = req.data & `MSC_MS_MASK;

	// Fault register loads, exception entry over software
	wire        load_cause     = exc.take && exc.cause_valid;
	wire        load_addr      = exc.take && exc.align;
	wire        wr_cause       = req.spr_write && (req.spr_num == `MSC_SPR_FAULT_CAUSE);
	wire        wr_addr        = req.spr_write && (req.spr_num == `MSC_SPR_FAULT_ADDR);

	// Decoded control values
	wire        precise_mode   = (fmode != 2'h0);
	wire [31:0] vector_sel     = ms_vector_top ? `MSC_VEC_HIGH : `MSC_VEC_LOW;

	// Gated causes toward the event flops
	wire        step_hit       = instr_done && !instr_fault && ms_step_trace;
	wire        jump_hit       = branch_done && ms_jump_trace;
	wire        async_hit      = (ext_int_req || dec_req) && ms_async_gate;
	wire        hw_fault_hit   = hw_fault_req && ms_hw_fault_on;
	wire        float_hit      = float_exc_req && precise_mode;

	// Strap value loaded at the first edge after reset
	wire        strap_load     = !strap_seen_reg;
	wire [31:0] strap_ms       = `MSC_MS_RESET | ({31'h0, vector_top_strap} << `MSC_B_VECTOR_TOP);

	// Next-state source, exception entry over software
	wire [1:0]  ms_pick        = exc.take ? 2'h2 : (wr_ms_hit ? 2'h1 : 2'h0);

	// Next machine state
	always_comb begin
		case (ms_pick)
			2'h2: begin
				ms_next = exc_ms;
			end
			2'h1: begin
				ms_next = wr_ms;
			end
			default: begin
				ms_next = ms_reg;
			end
		endcase
	end

	// Strap capture flag, set at the first edge after reset
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			strap_seen_reg <= 1'b0;
		end else begin
			strap_seen_reg <= 1'b1;
		end
	end

	// Machine state register, strap value first
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ms_reg <= `MSC_MS_RESET;
		end else if (strap_load) begin
			ms_reg <= strap_ms;
		end else begin
			ms_reg <= ms_next;
		end
	end

	// Save register takes old state on exception
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			save_reg <= 32'h00000000;
		end else if (exc.take) begin
			save_reg <= ms_reg;
		end
	end

	// Fault cause register, kept through reset
	always_ff @(posedge clk_sys) begin
		if (load_cause) begin
			cause_reg <= exc.cause;
		end else if (wr_cause) begin
			cause_reg <= req.data;
		end
	end

	// Fault address register, kept through reset
	always_ff @(posedge clk_sys) begin
		if (load_addr) begin
			addr_reg <= exc.addr;
		end else if (wr_addr) begin
			addr_reg <= req.data;
		end
	end

	// Run byte order for normal processing
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			run_little_reg <= 1'b0;
		end else begin
			run_little_reg <= ms_run_order;
		end
	end

	// External and decrementer interrupt gate
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			async_ok_reg <= 1'b0;
		end else begin
			async_ok_reg <= ms_async_gate;
		end
	end

	// Supervisor instructions allowed
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			super_ok_reg <= 1'b0;
		end else begin
			super_ok_reg <= !ms_nonsuper;
		end
	end

	// Float dispatch allowed
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			float_ok_reg <= 1'b0;
		end else begin
			float_ok_reg <= ms_float_on;
		end
	end

	// Machine check allowed
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			hw_fault_ok_reg <= 1'b0;
		end else begin
			hw_fault_ok_reg <= ms_hw_fault_on;
		end
	end

	// Single-step trace armed
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			step_trace_reg <= 1'b0;
		end else begin
			step_trace_reg <= ms_step_trace;
		end
	end

	// Strict program order while stepping
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			in_order_reg <= 1'b0;
		end else begin
			in_order_reg <= ms_step_trace;
		end
	end

	// Branch trace armed
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			jump_trace_reg <= 1'b0;
		end else begin
			jump_trace_reg <= ms_jump_trace;
		end
	end

	// Precise float exception mode
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			precise_reg <= 1'b0;
		end else begin
			precise_reg <= precise_mode;
		end
	end

	// Recoverable state flag
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			restart_ok_reg <= 1'b0;
		end else begin
			restart_ok_reg <= ms_restart_ok;
		end
	end

	// Vector table base
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			vector_base_reg <= 32'h00000000;
		end else begin
			vector_base_reg <= vector_sel;
		end
	end

	// Trace exception from step or branch
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			trace_reg <= 1'b0;
		end else begin
			trace_reg <= step_hit || jump_hit;
		end
	end

	// Gated external or decrementer interrupt
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			async_reg <= 1'b0;
		end else begin
			async_reg <= async_hit;
		end
	end

	// Gated machine check
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			hw_fault_reg <= 1'b0;
		end else begin
			hw_fault_reg <= hw_fault_hit;
		end
	end

	// Float assist call, never in ignore mode
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			float_reg <= 1'b0;
		end else begin
			float_reg <= float_hit;
		end
	end

	// Register views
	assign machine_state      = ms_reg;
	assign saved_state        = save_reg;
	assign access_fault_cause = cause_reg;
	assign fault_address      = addr_reg;

	// Decoded controls
	assign ctl                = '{
		run_little:        run_little_reg,
		async_ok:          async_ok_reg,
		super_ok:          super_ok_reg,
		float_dispatch_ok: float_ok_reg,
		hw_fault_ok:       hw_fault_ok_reg,
		step_trace:        step_trace_reg,
		in_order:          in_order_reg,
		jump_trace:        jump_trace_reg,
		float_precise:     precise_reg,
		restart_ok:        restart_ok_reg,
		vector_base:       vector_base_reg
	};

	// Gated events
	assign trace_exc          = trace_reg;
	assign async_take         = async_reg;
	assign hw_fault_take      = hw_fault_reg;
	assign float_assist_take  = float_reg;

endmodule : msc_machine_state_control

// ---- include/msc_cfg.svh ----
`ifndef MSC_CFG_SVH
`define MSC_CFG_SVH

// Special register numbers
`define MSC_SPR_FAULT_CAUSE  10'd18
`define MSC_SPR_FAULT_ADDR   10'd19

// Machine state bit positions, bit 0 is the least significant
`define MSC_B_TRAP_ORDER     16
`define MSC_B_ASYNC_GATE     15
`define MSC_B_NONSUPER       14
`define MSC_B_FLOAT_ON       13
`define MSC_B_HW_FAULT_ON    12
`define MSC_B_FMODE_HI       11
`define MSC_B_STEP_TRACE     10
`define MSC_B_JUMP_TRACE     9
`define MSC_B_FMODE_LO       8
`define MSC_B_VECTOR_TOP     6
`define MSC_B_RESTART_OK     1
`define MSC_B_RUN_ORDER      0

// Writable bits of the machine state register
`define MSC_MS_MASK          32'h0001FF43
// Reset value; the vector top bit comes from the strap
`define MSC_MS_RESET         32'h00000000

// Vector table bases
`define MSC_VEC_LOW          32'h00000000
`define MSC_VEC_HIGH         32'hFFF00000

`endif

// ---- include/msc_pkg.sv ----
package msc_pkg;

	// Write sources of the machine state register
	typedef enum logic [1:0] {
		MSC_WR_MOVE,
		MSC_WR_SYSCALL,
		MSC_WR_RETURN
	} msc_wr_src_t;

	// Register access request from the instruction side
	typedef struct packed {
		logic        ms_write;
		msc_wr_src_t ms_src;
		logic        spr_write;
		logic [9:0]  spr_num;
		logic [31:0] data;
	} msc_req_t;

	// Exception entry event
	typedef struct packed {
		logic        take;
		logic        align;
		logic        cause_valid;
		logic [31:0] cause;
		logic [31:0] addr;
		logic [31:0] new_ms;
	} msc_exc_t;

	// Decoded controls toward the core
	typedef struct packed {
		logic       run_little;
		logic       async_ok;
		logic       super_ok;
		logic       float_dispatch_ok;
		logic       hw_fault_ok;
		logic       step_trace;
		logic       in_order;
		logic       jump_trace;
		logic       float_precise;
		logic       restart_ok;
		logic [31:0] vector_base;
	} msc_ctl_t;

endpackage : msc_pkg

// ---- sim/msc_checker.sv ----
`timescale 1ns/1ns
module msc_checker (
	input wire logic              clk_sys,
	input wire logic              resetn,
	input wire msc_pkg::msc_exc_t exc,
	input wire logic [31:0]       machine_state,
	input wire logic [31:0]       saved_state,
	input wire logic [31:0]       fault_address,
	input wire msc_pkg::msc_ctl_t ctl
);
	import msc_pkg::*;
	logic live_reg;
	// Skips the first edge after reset, before ctl has decoded
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) live_reg <= 1'b0;
		else live_reg <= 1'b1;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	sequence s_entry;
		exc.take;
	endsequence
	a_trap_entry: assert property (s_entry |=> machine_state[0] == $past(machine_state[16])
		&& saved_state == $past(machine_state)) else $error("entry state wrong");
	a_fault_addr: assert property (s_entry ##0 exc.align |=> fault_address == $past(exc.addr))
		else $error("fault address wrong");
	a_run_order: assert property (ctl.run_little == $past(machine_state[0])) else $error("order wrong");
	a_gate_priv: assert property (live_reg |-> ctl.async_ok == $past(machine_state[15])
		&& ctl.super_ok == !$past(machine_state[14])) else $error("gate or privilege wrong");
	a_unit_enables: assert property (ctl.float_dispatch_ok == $past(machine_state[13])
		&& ctl.hw_fault_ok == $past(machine_state[12])) else $error("unit enable wrong");
	a_trace_ctl: assert property (ctl.step_trace == $past(machine_state[10]) && ctl.in_order == ctl.step_trace
		&& ctl.jump_trace == $past(machine_state[9])) else $error("trace control wrong");
	a_float_mode: assert property (ctl.float_precise == ($past(machine_state[11]) || $past(machine_state[8])))
		else $error("float mode wrong");
	a_vector_base: assert property (ctl.vector_base == ($past(machine_state[6]) ? 32'hFFF00000 : 32'h00000000))
		else $error("vector base wrong");
	a_restart_flag: assert property (ctl.restart_ok == $past(machine_state[1])) else $error("restart flag wrong");
	a_reserved_zero: assert property ((machine_state & ~32'h0001FF43) == 32'h00000000)
		else $error("reserved bit set");
endmodule : msc_checker
bind msc_machine_state_control msc_checker u_msc_checker (.clk_sys(clk_sys), .resetn(resetn), .exc(exc),
	.machine_state(machine_state), .saved_state(saved_state), .fault_address(fault_address), .ctl(ctl));

// ---- sim/msc_machine_state_control_test.sv ----
`timescale 1ns/1ns
module msc_machine_state_control_test;
	import msc_pkg::*;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	msc_req_t    req = '0;
	msc_exc_t    exc = '0;
	logic [6:0]  ev = 7'h00;
	logic [31:0] ms, sv, fc, fa;
	msc_ctl_t    ctl;
	logic        tr, at, ht, ft;
	logic        strap = 1'b1;
	int          errors = 0;
	int          samples_checked = 0;
	// Free-running system clock
	always #5 clk_sys = ~clk_sys;
	msc_machine_state_control u_msc_machine_state_control (.clk_sys(clk_sys), .resetn(resetn), .vector_top_strap(strap),
		.req(req), .exc(exc), .instr_done(ev[6]), .instr_fault(ev[5]), .branch_done(ev[4]), .ext_int_req(ev[3]),
		.dec_req(ev[2]), .hw_fault_req(ev[1]), .float_exc_req(ev[0]), .machine_state(ms), .saved_state(sv),
		.access_fault_cause(fc), .fault_address(fa), .ctl(ctl), .trace_exc(tr), .async_take(at),
		.hw_fault_take(ht), .float_assist_take(ft));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task tick;
		@(posedge clk_sys);
		#1;
	endtask : tick
	task wr_ms(input logic [31:0] d);
		req = '{1'b1, MSC_WR_MOVE, 1'b0, 10'h000, d};
		tick;
		req = '0;
		tick;
	endtask : wr_ms
	task wr_spr(input logic [9:0] n, input logic [31:0] d);
		req = '{1'b0, MSC_WR_MOVE, 1'b1, n, d};
		tick;
		req = '0;
		tick;
	endtask : wr_spr
	task trap(input logic [31:0] nm, input logic al, input logic [31:0] a);
		exc = '{1'b1, al, al, 32'hA5A50000, a, nm};
		req = '{1'b1, MSC_WR_MOVE, 1'b0, 10'h000, 32'hFFFFFFFF};
		tick;
		exc = '0;
		req = '0;
		tick;
	endtask : trap
	task fire(input logic [6:0] v, input logic [3:0] want);
		ev = v;
		tick;
		ev = 7'h00;
		chk({28'h0000000, tr, at, ht, ft}, {28'h0000000, want});
		tick;
	endtask : fire
	task end_sim;
		$display("checked %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_sim
	// Main sequence
	initial begin
		repeat (12) @(posedge clk_sys);
		#1 resetn = 1'b1;
		tick;
		tick;
		chk(ms, 32'h00000040);
		chk(ctl.vector_base, 32'hFFF00000);
		strap = 1'b0;
		for (int s = 0; s < 3; s++) begin
			req = '{1'b1, msc_wr_src_t'(s), 1'b0, 10'h000, 32'hFFFFFFFF};
			tick;
			req = '0;
			tick;
			chk(ms, 32'h0001FF43);
			wr_ms(32'h00000000);
		end
		chk(ctl.vector_base, 32'h00000000);
		chk(ctl.float_precise, 1'b0);
		wr_ms(32'h00000100);
		chk(ctl.float_precise, 1'b1);
		$display("test writes done");
		wr_ms(32'h0001FF43);
		fire(7'h40, 4'h8);
		fire(7'h60, 4'h0);
		fire(7'h10, 4'h8);
		fire(7'h08, 4'h4);
		fire(7'h04, 4'h4);
		fire(7'h02, 4'h2);
		fire(7'h01, 4'h1);
		wr_ms(32'h00000000);
		fire(7'h5F, 4'h0);
		$display("test events done");
		wr_ms(32'h00010000);
		trap(32'h00001000, 1'b1, 32'h12345678);
		chk(ms, 32'h00001001);
		chk(sv, 32'h00010000);
		chk(fc, 32'hA5A50000);
		chk(fa, 32'h12345678);
		trap(32'h00000001, 1'b0, 32'h0BADF00D);
		chk(ms, 32'h00000000);
		chk(fa, 32'h12345678);
		$display("test entry done");
		wr_spr(10'd18, 32'h0000C0DE);
		wr_spr(10'd19, 32'h0000BEEF);
		resetn = 1'b0;
		tick;
		chk(ms, 32'h00000000);
		chk(fc, 32'h0000C0DE);
		chk(fa, 32'h0000BEEF);
		resetn = 1'b1;
		tick;
		tick;
		chk(ms, 32'h00000000);
		chk(ctl.vector_base, 32'h00000000);
		$display("test reset hold done");
		end_sim;
	end
endmodule : msc_machine_state_control_test
